// *** rtl/cms_pkg.sv ***
// Constants for the control mode select latch: modes, states, map.
// Assumes a single 250 MHz clock domain and an APB register bus.
package cms_pkg;

	// Control modes latched at power-up
	typedef enum logic [1:0] {
		CMS_MODE_SPEED  = 2'h0,	// Native speed control
		CMS_MODE_POS    = 2'h1,	// Native position control
		CMS_MODE_LSPEED = 2'h2,	// Legacy-compatible speed control
		CMS_MODE_LPOS   = 2'h3	// Legacy-compatible position control
	} cms_mode_t;

	// Sequencer states, Gray coded along settle, restore, run
	typedef enum logic [2:0] {
		CMS_ST_SETTLE  = 3'h0,	// Waiting for switch synchronisers
		CMS_ST_RESTORE = 3'h1,	// Writing mode defaults
		CMS_ST_RUN     = 3'h3,	// Normal operation
		CMS_ST_ERROR   = 3'h2	// Illegal switch set, locked
	} cms_state_t;

	// Register byte offsets
	localparam logic [11:0] CMS_OFS_STATUS   = 12'h000;	// Mode and state, read only
	localparam logic [11:0] CMS_OFS_IN8_FUNC = 12'h004;	// Input 8 function select
	localparam logic [11:0] CMS_OFS_SWITCH   = 12'h008;	// Live switch levels, read only
	localparam logic [11:0] CMS_OFS_OPDATA   = 12'h040;	// First operation data word

	// Status field positions
	localparam int CMS_ST_MODE_LSB = 0;	// Two mode bits
	localparam int CMS_ST_LEGACY   = 2;	// Legacy mapping active
	localparam int CMS_ST_CFG_ERR  = 3;	// Configuration error
	localparam int CMS_ST_RESTORED = 4;	// Defaults were reloaded
	localparam int CMS_ST_LATCHED  = 5;	// Mode has been latched

	// Input 8 function codes
	localparam logic [3:0] CMS_FUNC_NONE   = 4'h0;	// No function, value after reset
	localparam logic [3:0] CMS_FUNC_THERMO = 4'h1;	// Thermostat overheat input

	// Counts and defaults
	localparam logic [2:0]  CMS_SETTLE_CYC  = 3'h4;	// Cycles before switches are trusted
	localparam int          CMS_OPDATA_NUM  = 16;	// Stored operation data entries
	localparam logic [31:0] CMS_DEF_SPEED   = 32'h0000_0000;	// Default entry, speed modes
	localparam logic [31:0] CMS_DEF_POS     = 32'h0000_0000;	// Default entry, position modes

endpackage : cms_pkg

// *** rtl/cms_opdata_mem.sv ***
// Small operation data store, one write port and one registered read port.
// Assumes the caller never reads and writes the same cycle with a conflict.
`timescale 1ns/1ps
module cms_opdata_mem #(
	parameter int DEPTH = 16,	// Number of entries
	parameter int WIDTH = 32,	// Bits per entry
	parameter int AW    = 4	// Address width
) (
	input  wire logic             clk_i,	// Core clock
	input  wire logic             rst_b_i,	// Sync reset, active low
	input  wire logic             we_i,	// Write strobe
	input  wire logic [AW-1:0]    waddr_i,	// Write address
	input  wire logic [WIDTH-1:0] wdata_i,	// Write data
	input  wire logic [AW-1:0]    raddr_i,	// Read address
	output logic      [WIDTH-1:0] rdata_o	// Registered read data
);

	// All storage in one struct
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;	// Entries
		logic [WIDTH-1:0]            rdata;	// Read register
	} cms_mem_t;

	cms_mem_t q_r;	// Current state
	cms_mem_t q_nxt;	// Next state

	// Entries keep their contents through reset; only the read register clears
	always_comb
	begin
		q_nxt       = q_r;
		q_nxt.rdata = q_r.mem[raddr_i];
		if (we_i)
		begin
			q_nxt.mem[waddr_i] = wdata_i;
		end
		if (!rst_b_i)
		begin
			q_nxt.rdata = '0;
		end
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		q_r <= q_nxt;
	end

	assign rdata_o = q_r.rdata;

endmodule : cms_opdata_mem

// *** rtl/cms_mode_latch.sv ***
// Control mode select latch with APB register access and default restore.
// Assumes switch pins are asynchronous and the stored previous mode is synchronous.
//
// Overview of operation
// - Both switches off selects speed mode, 16 entries
// - Switch A on, B off selects position mode
// - A off, B and supply on: legacy speed
// - A, B and supply on: legacy position
// - Switches sampled once after reset only
// - Mode change reloads all parameters with defaults
// - Legacy modes use legacy signal mapping
// - Input 8 unused; thermostat only when assigned
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
module cms_mode_latch #(
	parameter int NUM_OPDATA = cms_pkg::CMS_OPDATA_NUM	// Operation data entries
) (
	input  wire logic        clk_i,	// Core clock, 250 MHz
	input  wire logic        rst_b_i,	// Sync reset, active low
	input  wire logic        mode_switch_a_i,	// Switch A pin, asynchronous
	input  wire logic        mode_switch_b_i,	// Switch B pin, asynchronous
	input  wire logic        supply_select_switch_i,	// Supply switch pin, asynchronous
	input  wire logic        general_input_8_i,	// Input 8 pin, asynchronous
	input  wire logic [1:0]  prev_mode_i,	// Mode stored at last power-up
	input  wire logic        prev_valid_i,	// Stored mode is valid
	input  wire logic        psel,	// APB select
	input  wire logic        penable,	// APB enable
	input  wire logic        pwrite,	// APB direction
	input  wire logic [11:0] paddr,	// APB byte address
	input  wire logic [31:0] pwdata,	// APB write data
	output logic      [31:0] prdata,	// APB read data
	output logic             pready,	// APB ready
	output logic             pslverr,	// APB error
	output logic      [1:0]  mode_o,	// Latched control mode
	output logic             mode_valid_o,	// Mode latched and usable
	output logic             legacy_map_o,	// Legacy signal mapping select
	output logic             cfg_error_o,	// Illegal switch combination
	output logic             motor_enable_o,	// Motor output permitted
	output logic             overheat_alarm_o	// Thermostat overheat alarm
);

	localparam int AW = $clog2(NUM_OPDATA);	// Entry index width

	// Whole module state
	typedef struct packed {
		cms_pkg::cms_state_t st;	// Sequencer state
		logic [2:0]          cnt;	// Settle counter
		logic [1:0]          mode;	// Latched mode
		logic                err;	// Configuration error
		logic                restored;	// Defaults reloaded this power-up
		logic [AW-1:0]       idx;	// Restore walk index
		logic [3:0]          in8_func;	// Input 8 function select
		logic [2:0]          sw_s1;	// Switch sync, first stage
		logic [2:0]          sw_s2;	// Switch sync, second stage
		logic                th_s1;	// Input 8 sync, first stage
		logic                th_s2;	// Input 8 sync, second stage
		logic [31:0]         rdata;	// Register read data
		logic                mem_sel;	// Read addresses the data store
	} cms_regs_t;

	cms_regs_t q_r;	// Current state
	cms_regs_t q_nxt;	// Next state

	logic          setup;	// APB setup phase
	logic          access;	// APB access completing
	logic          in_mem;	// Address inside data store
	logic          mapped;	// Address decodes
	logic          latch_ev;	// Cycle the switches are judged
	logic          legal;	// Switch set is a defined mode
	logic [1:0]    new_mode;	// Decoded mode
	logic          we;	// Store write strobe
	logic [AW-1:0] waddr;	// Store write address
	logic [31:0]   wdata;	// Store write data
	logic [31:0]   mem_rdata;	// Store read data
	logic [31:0]   def_word;	// Default entry for latched mode

	// Address decode; the data store window is NUM_OPDATA words
	assign in_mem = (paddr >= cms_pkg::CMS_OFS_OPDATA) &&
		(paddr < cms_pkg::CMS_OFS_OPDATA + 12'(NUM_OPDATA * 4));
	assign mapped = in_mem || (paddr == cms_pkg::CMS_OFS_STATUS) ||
		(paddr == cms_pkg::CMS_OFS_IN8_FUNC) || (paddr == cms_pkg::CMS_OFS_SWITCH);
	assign setup  = psel && !penable;
	// Bus stalls while defaults are being written, so software never sees half a reload
	assign pready  = psel && penable && (q_r.st != cms_pkg::CMS_ST_RESTORE);
	assign access  = pready;
	assign pslverr = pready && !mapped;
	assign prdata  = q_r.mem_sel ? mem_rdata : q_r.rdata;

	assign latch_ev = (q_r.st == cms_pkg::CMS_ST_SETTLE) && (q_r.cnt == cms_pkg::CMS_SETTLE_CYC);

	// Switch decode: sw_s2 is {supply, B, A}
	always_comb
	begin
		legal    = 1'b1;
		new_mode = cms_pkg::CMS_MODE_SPEED;
		unique case (q_r.sw_s2)
			3'h0, 3'h4: new_mode = cms_pkg::CMS_MODE_SPEED;
			3'h1, 3'h5: new_mode = cms_pkg::CMS_MODE_POS;
			3'h6:       new_mode = cms_pkg::CMS_MODE_LSPEED;
			3'h7:       new_mode = cms_pkg::CMS_MODE_LPOS;
			3'h2, 3'h3: legal = 1'b0;
		endcase
	end

	// Default entry depends on the mode just latched
	assign def_word = q_r.mode[0] ? cms_pkg::CMS_DEF_POS : cms_pkg::CMS_DEF_SPEED;

	// Store port: restore walk owns it, otherwise bus writes in run state
	always_comb
	begin
		we    = 1'b0;
		waddr = paddr[AW+1:2];
		wdata = pwdata;
		if (q_r.st == cms_pkg::CMS_ST_RESTORE)
		begin
			we    = 1'b1;
			waddr = q_r.idx;
			wdata = def_word;
		end
		else if (access && pwrite && in_mem && (q_r.st == cms_pkg::CMS_ST_RUN))
		begin
			we = 1'b1;
		end
	end

	// Next state of the whole block
	always_comb
	begin
		q_nxt       = q_r;
		q_nxt.sw_s1 = {supply_select_switch_i, mode_switch_b_i, mode_switch_a_i};
		q_nxt.sw_s2 = q_r.sw_s1;
		q_nxt.th_s1 = general_input_8_i;
		q_nxt.th_s2 = q_r.th_s1;

		// Sequencer
		unique case (q_r.st)
			cms_pkg::CMS_ST_SETTLE:
			begin
				q_nxt.cnt = q_r.cnt + 3'h1;
				if (latch_ev)
				begin
					q_nxt.cnt  = q_r.cnt;
					q_nxt.mode = new_mode;
					if (!legal)
					begin
						q_nxt.err = 1'b1;
						q_nxt.st  = cms_pkg::CMS_ST_ERROR;
					end
					else if (!prev_valid_i || (prev_mode_i != new_mode))
					begin
						q_nxt.st  = cms_pkg::CMS_ST_RESTORE;
						q_nxt.idx = '0;
					end
					else
					begin
						q_nxt.st = cms_pkg::CMS_ST_RUN;
					end
				end
			end
			cms_pkg::CMS_ST_RESTORE:
			begin
				// Parameters return to their defaults, input 8 back to no function
				q_nxt.in8_func = cms_pkg::CMS_FUNC_NONE;
				q_nxt.idx      = q_r.idx + AW'(1);
				if (q_r.idx == AW'(NUM_OPDATA - 1))
				begin
					q_nxt.restored = 1'b1;
					q_nxt.st       = cms_pkg::CMS_ST_RUN;
				end
			end
			cms_pkg::CMS_ST_RUN:
			begin
				// Mode stays as latched; later switch moves are ignored
				q_nxt.st = cms_pkg::CMS_ST_RUN;
			end
			cms_pkg::CMS_ST_ERROR:
			begin
				// Locked until reset; motor stays off
				q_nxt.st = cms_pkg::CMS_ST_ERROR;
			end
		endcase

		// Register writes take effect on the completing edge
		if (access && pwrite && (paddr == cms_pkg::CMS_OFS_IN8_FUNC) &&
			(q_r.st == cms_pkg::CMS_ST_RUN))
		begin
			q_nxt.in8_func = pwdata[3:0];
		end

		// Read data captured in setup so it comes from a register
		if (setup)
		begin
			q_nxt.mem_sel = in_mem;
			q_nxt.rdata   = '0;
			if (paddr == cms_pkg::CMS_OFS_STATUS)
			begin
				q_nxt.rdata[cms_pkg::CMS_ST_MODE_LSB +: 2] = q_r.mode;
				q_nxt.rdata[cms_pkg::CMS_ST_LEGACY]   = legacy_map_o;
				q_nxt.rdata[cms_pkg::CMS_ST_CFG_ERR]  = q_r.err;
				q_nxt.rdata[cms_pkg::CMS_ST_RESTORED] = q_r.restored;
				q_nxt.rdata[cms_pkg::CMS_ST_LATCHED]  = mode_valid_o;
			end
			else if (paddr == cms_pkg::CMS_OFS_IN8_FUNC)
			begin
				q_nxt.rdata[3:0] = q_r.in8_func;
			end
			else if (paddr == cms_pkg::CMS_OFS_SWITCH)
			begin
				q_nxt.rdata[2:0] = q_r.sw_s2;
			end
		end

		// Synchronous reset of control state; synchroniser stages clear too
		if (!rst_b_i)
		begin
			q_nxt = '0;
		end
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		q_r <= q_nxt;
	end

	// Operation data store
	cms_opdata_mem #(
		.DEPTH (NUM_OPDATA),
		.WIDTH (32),
		.AW    (AW)
	) u_opdata (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.we_i    (we),
		.waddr_i (waddr),
		.wdata_i (wdata),
		.raddr_i (paddr[AW+1:2]),
		.rdata_o (mem_rdata)
	);

	// Outputs
	assign mode_o         = q_r.mode;
	assign mode_valid_o   = (q_r.st == cms_pkg::CMS_ST_RUN);
	assign legacy_map_o   = mode_valid_o && q_r.mode[1];
	assign cfg_error_o    = q_r.err;
	assign motor_enable_o = (q_r.st == cms_pkg::CMS_ST_RUN) && !q_r.err;
	// Thermostat is opened contact, seen as a low level on the assigned pin
	assign overheat_alarm_o = (q_r.in8_func == cms_pkg::CMS_FUNC_THERMO) && !q_r.th_s2;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	// Walk spelled with fixed delays; the index pins both ends, so no long repetition
	sequence s_restore_start;
		(q_r.st == cms_pkg::CMS_ST_RESTORE) && (q_r.idx == AW'(0));
	endsequence

	sequence s_restore_walk;
		s_restore_start ##15 ((q_r.st == cms_pkg::CMS_ST_RESTORE) &&
			(q_r.idx == AW'(NUM_OPDATA - 1))) ##1 mode_valid_o;
	endsequence

	a_speed_decode: assert property (latch_ev && q_r.sw_s2[1:0] == 2'h0 |=>
		mode_o == cms_pkg::CMS_MODE_SPEED && !cfg_error_o)
		else $error("switches off did not give speed mode");
	a_pos_decode: assert property (latch_ev && q_r.sw_s2[1:0] == 2'h1 |=>
		mode_o == cms_pkg::CMS_MODE_POS && !cfg_error_o)
		else $error("switch A alone did not give position mode");
	a_lspeed_decode: assert property (latch_ev && q_r.sw_s2 == 3'h6 |=>
		mode_o == cms_pkg::CMS_MODE_LSPEED)
		else $error("legacy speed not selected");
	a_lpos_decode: assert property (latch_ev && q_r.sw_s2 == 3'h7 |=>
		mode_o == cms_pkg::CMS_MODE_LPOS)
		else $error("legacy position not selected");
	a_mode_frozen: assert property (q_r.st != cms_pkg::CMS_ST_SETTLE |=>
		$stable(mode_o) && $stable(cfg_error_o))
		else $error("latched mode changed after power-up");
	a_restore_on_change: assert property (latch_ev && legal &&
		(!prev_valid_i || prev_mode_i != new_mode) |=> s_restore_walk)
		else $error("default reload did not run for a mode change");
	a_no_restore_same: assert property (latch_ev && legal && prev_valid_i &&
		prev_mode_i == new_mode |=> mode_valid_o && !q_r.restored)
		else $error("defaults reloaded although mode unchanged");
	a_legacy_map: assert property (mode_valid_o && mode_o[1] |-> legacy_map_o)
		else $error("legacy mapping missing in legacy mode");
	a_in8_unused: assert property (q_r.in8_func != cms_pkg::CMS_FUNC_THERMO |->
		!overheat_alarm_o)
		else $error("overheat raised without thermostat assignment");
	a_cfg_error: assert property (latch_ev && !legal |=>
		cfg_error_o && !motor_enable_o ##1 cfg_error_o && !motor_enable_o)
		else $error("illegal switches did not lock the motor off");

endmodule : cms_mode_latch

// *** verification/cms_switch_model.sv ***
// Model of the hand-set DIP switches and the thermostat contact.
// Assumes the bench sets the switch word; levels move after a clock edge.
`timescale 1ns/1ps
module cms_switch_model (
	input  wire logic       clk_i,	// Core clock
	input  wire logic [2:0] set_i,	// Wanted {supply,B,A}, high=on
	input  wire logic       heat_i,	// Resistor overheated
	output logic            sw_a_o,	// Mode switch A pin
	output logic            sw_b_o,	// Mode switch B pin
	output logic            sw_s_o,	// Supply select pin
	output logic            in8_o	// Thermostat contact on input 8
);
	// Switch levels follow the setting one edge later, like a hand move
	always_ff @(posedge clk_i)
	begin
		{sw_s_o, sw_b_o, sw_a_o} <= set_i;
		in8_o                    <= ~heat_i;	// Normally closed: opens when hot
	end
endmodule : cms_switch_model

// *** verification/tb.sv ***
// Self-checking bench for the mode latch: switch sweep, hold, restore, input 8.
// Assumes one 250 MHz clock, the switch model and an APB master task.
`timescale 1ns/1ps
module tb;
	logic        clk_i = 1'b0;	// Core clock
	logic        rst_b_i = 1'b0;	// Reset, active low
	logic [2:0]  sw_set = 3'h0;	// {supply,B,A}
	logic        heat = 1'b0;	// Overheat request
	logic        sw_a, sw_b, sw_s, in8;	// Model pins
	logic [1:0]  pmode = 2'h0;	// Stored mode
	logic        pvalid = 1'b0;	// Stored mode valid
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;	// APB control
	logic [11:0] paddr = 12'h000;	// APB address
	logic [31:0] pwdata = 32'h0, prdata, rd;	// APB data, last read
	logic        pready, pslverr, er, mvalid, legacy, cerr, motor, alarm;	// Outputs
	logic [1:0]  mode;	// Latched mode
	logic [31:0] ent [16];	// Expected entries
	int          err_count = 0;	// Mismatches
	int          compares = 0;	// Comparisons

	// 4 ns clock
	always #2 clk_i = ~clk_i;

	cms_switch_model sw_u (.clk_i(clk_i), .set_i(sw_set), .heat_i(heat), .sw_a_o(sw_a),
		.sw_b_o(sw_b), .sw_s_o(sw_s), .in8_o(in8));

	cms_mode_latch dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .mode_switch_a_i(sw_a),
		.mode_switch_b_i(sw_b), .supply_select_switch_i(sw_s), .general_input_8_i(in8),
		.prev_mode_i(pmode), .prev_valid_i(pvalid), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mode_o(mode), .mode_valid_o(mvalid), .legacy_map_o(legacy),
		.cfg_error_o(cerr), .motor_enable_o(motor), .overheat_alarm_o(alarm));

	// Verdict and end of run
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	// One comparison
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// A bounded wait ran out
	task automatic hang(input string nm);
		chk(nm, 32'h1, 32'h0);
		summarize();
	endtask : hang

	// One APB transfer; answer taken at the edge where pready is high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge clk_i);
			if (pready === 1'b1)
			begin
				rd = prdata;
				er = pslverr;
				break;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 40)
			hang("apb_ready");
	endtask : apb

	// Power cycle with switches set ahead of release
	task automatic boot(input logic [2:0] s, input logic pv, input logic [1:0] pm);
		int n;
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		sw_set <= s;
		pvalid <= pv;
		pmode <= pm;
		repeat (10) @(posedge clk_i);
		chk("reset_outs", 32'h0, {mvalid, cerr, motor});
		rst_b_i <= 1'b1;
		for (n = 0; n < 60; n++)
		begin
			@(negedge clk_i);
			if (mvalid === 1'b1 || cerr === 1'b1)
				break;
		end
		if (n == 60)
			hang("latch_done");
	endtask : boot

	// Expected {error, mode} for a switch set {supply,B,A}
	function automatic logic [2:0] dec(input logic [2:0] s);
		if (!s[1])
			return {2'h0, s[0]};
		if (!s[2])
			return 3'h4;
		return {2'h1, s[0]};
	endfunction : dec

	// Main sequence
	initial
	begin
		logic [2:0] e;
		logic       pv;
		logic [1:0] pm;
		int         k;
		void'($urandom(88071));
		// Every switch set with a random stored mode
		for (k = 0; k < 8; k++)
		begin
			pv = 1'($urandom_range(1, 0));
			pm = 2'($urandom_range(3, 0));
			boot(k[2:0], pv, pm);
			e = dec(k[2:0]);
			chk("cfg_error", {31'h0, e[2]}, {31'h0, cerr});
			chk("motor_en", {31'h0, !e[2]}, {31'h0, motor});
			apb(1'b0, cms_pkg::CMS_OFS_STATUS, 32'h0);
			if (!e[2])
			begin
				chk("mode", {30'h0, e[1:0]}, {30'h0, mode});
				chk("legacy", {31'h0, e[1]}, {31'h0, legacy});
				chk("status", {26'h0, 1'b1, !pv || pm != e[1:0], 1'b0, e[1], e[1:0]}, rd);
			end
			else
				chk("status_err", 32'h8, rd & 32'h28);
		end
		// Error state holds; writes refused outside run
		boot(3'h2, 1'b0, 2'h0);
		apb(1'b1, cms_pkg::CMS_OFS_IN8_FUNC, 32'h1);
		sw_set <= 3'h0;
		repeat (20) @(posedge clk_i);
		apb(1'b0, cms_pkg::CMS_OFS_IN8_FUNC, 32'h0);
		chk("err_in8", 32'h0, rd);
		chk("err_hold", 32'h2, {cerr, motor});
		// Later switch moves are ignored but visible live
		boot(3'h1, 1'b1, 2'h1);
		sw_set <= 3'h6;
		repeat (20) @(posedge clk_i);
		chk("mode_hold", 32'h1, {30'h0, mode});
		apb(1'b0, cms_pkg::CMS_OFS_SWITCH, 32'h0);
		chk("switch_live", 32'h6, rd & 32'h7);
		// Random entries survive a boot into the same mode
		boot(3'h0, 1'b1, 2'h0);
		for (k = 0; k < 16; k++)
		begin
			ent[k] = $urandom;
			apb(1'b1, 12'(cms_pkg::CMS_OFS_OPDATA + 4 * k), ent[k]);
		end
		apb(1'b1, cms_pkg::CMS_OFS_IN8_FUNC, 32'h1);
		boot(3'h0, 1'b1, 2'h0);
		apb(1'b0, cms_pkg::CMS_OFS_STATUS, 32'h0);
		chk("no_restore", 32'h0, rd & 32'h10);
		for (k = 0; k < 16; k++)
		begin
			apb(1'b0, 12'(cms_pkg::CMS_OFS_OPDATA + 4 * k), 32'h0);
			chk("entry_kept", ent[k], rd);
		end
		// Mode change reloads every entry and input 8 function
		boot(3'h1, 1'b1, 2'h0);
		for (k = 0; k < 16; k++)
		begin
			apb(1'b0, 12'(cms_pkg::CMS_OFS_OPDATA + 4 * k), 32'h0);
			chk("entry_def", cms_pkg::CMS_DEF_POS, rd);
		end
		apb(1'b0, cms_pkg::CMS_OFS_IN8_FUNC, 32'h0);
		chk("in8_def", 32'h0, rd);
		// Thermostat only once assigned
		heat <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk("alarm_none", 32'h0, {31'h0, alarm});
		apb(1'b1, cms_pkg::CMS_OFS_IN8_FUNC, 32'h2);
		repeat (8) @(posedge clk_i);
		chk("alarm_other", 32'h0, {31'h0, alarm});
		apb(1'b1, cms_pkg::CMS_OFS_IN8_FUNC, {28'h0, cms_pkg::CMS_FUNC_THERMO});
		repeat (8) @(posedge clk_i);
		chk("alarm_on", 32'h1, {31'h0, alarm});
		heat <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk("alarm_off", 32'h0, {31'h0, alarm});
		// Unmapped address and read-only write
		apb(1'b0, 12'h00C, 32'h0);
		chk("unmapped", 32'h1, {31'h0, er});
		apb(1'b1, cms_pkg::CMS_OFS_STATUS, 32'h0);
		apb(1'b0, cms_pkg::CMS_OFS_STATUS, 32'h0);
		chk("status_ro", 32'h21, rd & 32'h2F);
		summarize();
	end
endmodule : tb
